// ---- rtl/safe_signal_telegram_mapper.sv ----
// packs the device-to-controller safe telegram and unpacks the reply
// assumes byte links with valid/ready handshakes, one clock, sync reset
`timescale 1ns/10ps
module safe_signal_telegram_mapper #(
    parameter logic [23:0] CRC_POLY = ssm_pkg::CRC_POLY_DEF,
    parameter logic [23:0] CRC_SEED = ssm_pkg::CRC_SEED_DEF
) (
    input  wire logic           mclk,
    input  wire logic           rst_b,
    input  wire logic [1:0]     func_mode,
    input  wire logic           func_a_warn_field_free,
    input  wire logic           func_a_prot_field_free,
    input  wire logic           func_b_warn_field_free,
    input  wire logic           func_b_prot_field_free,
    input  wire logic [7:0]     tx_status,
    input  wire logic           tx_start,
    input  wire logic           tx_ready,
    output logic                tx_valid,
    output logic [7:0]          tx_data,
    output logic                tx_last,
    output logic                tx_busy,
    input  wire logic           rx_valid,
    input  wire logic           rx_first,
    input  wire logic [7:0]     rx_data,
    output logic                rx_ready,
    output ssm_pkg::cmd_t       cmd,
    output ssm_pkg::field_pair_t release_a,
    output logic [7:0]          rx_status,
    output logic                telegram_ok,
    output logic                crc_err
);

    // ****************************************
    // send side
    // ****************************************
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    tx_state_t             tx_state_ff;
    logic [3:0]            tx_idx_ff;
    logic [23:0]           tx_crc_ff;
    logic [7:0]            tx_data_ff;
    logic                  tx_valid_ff;
    logic                  tx_last_ff;
    ssm_pkg::field_pair_t  fa_ff;
    ssm_pkg::field_pair_t  fb_ff;
    logic [7:0]            st_ff;
    logic [23:0]           nxt_tx_crc;
    logic [23:0]           crc_now;
    logic [3:0]            nxt_tx_idx;
    logic                  tx_take;

    assign tx_take    = tx_valid_ff & tx_ready;
    assign nxt_tx_idx = 4'(tx_idx_ff + 4'h1);
    assign nxt_tx_crc = ssm_pkg::crc_byte(tx_crc_ff, tx_data_ff, CRC_POLY);
    // crc stops moving once the status byte has gone
    assign crc_now    = (tx_idx_ff < ssm_pkg::IN_B_CRC_HH) ? nxt_tx_crc : tx_crc_ff;

    // byte at a position of the outgoing telegram
    function automatic logic [7:0] in_byte(input logic [3:0]  idx,
                                           input logic [1:0]  a,
                                           input logic [1:0]  b,
                                           input logic [7:0]  st,
                                           input logic [23:0] crc);
        case (idx)
            ssm_pkg::IN_B_FUNC_A: in_byte = {6'h00, a};
            ssm_pkg::IN_B_FUNC_B: in_byte = {6'h00, b};
            ssm_pkg::IN_B_STATUS: in_byte = st;
            ssm_pkg::IN_B_CRC_HH: in_byte = crc[23:16];
            ssm_pkg::IN_B_CRC_LH: in_byte = crc[15:8];
            ssm_pkg::IN_B_CRC_LL: in_byte = crc[7:0];
            default:              in_byte = 8'h00;
        endcase
    endfunction : in_byte

    // snapshot at start so a telegram never mixes two scans
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_state_ff <= TX_IDLE;
            tx_idx_ff   <= 4'h0;
            tx_crc_ff   <= CRC_SEED;
            tx_data_ff  <= 8'h00;
            tx_valid_ff <= 1'b0;
            tx_last_ff  <= 1'b0;
            fa_ff       <= '0;
            fb_ff       <= '0;
            st_ff       <= 8'h00;
        end else begin
            case (tx_state_ff)
                TX_IDLE: begin
                    if (tx_start) begin
                        fa_ff       <= {func_a_prot_field_free, func_a_warn_field_free};
                        fb_ff       <= {func_b_prot_field_free, func_b_warn_field_free};
                        st_ff       <= tx_status;
                        tx_crc_ff   <= CRC_SEED;
                        tx_idx_ff   <= ssm_pkg::IN_B_FUNC_A;
                        tx_data_ff  <= {6'h00, func_a_prot_field_free, func_a_warn_field_free};
                        tx_valid_ff <= 1'b1;
                        tx_state_ff <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_take) begin
                        if (tx_idx_ff == ssm_pkg::IN_B_CRC_LL) begin
                            tx_valid_ff <= 1'b0;
                            tx_last_ff  <= 1'b0;
                            tx_state_ff <= TX_IDLE;
                        end else begin
                            tx_crc_ff  <= crc_now;
                            tx_idx_ff  <= nxt_tx_idx;
                            tx_last_ff <= (nxt_tx_idx == ssm_pkg::IN_B_CRC_LL);
                            tx_data_ff <= in_byte(nxt_tx_idx, fa_ff, fb_ff, st_ff, crc_now);
                        end
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    assign tx_valid = tx_valid_ff;
    assign tx_data  = tx_data_ff;
    assign tx_last  = tx_last_ff;
    assign tx_busy  = tx_valid_ff;

    // ****************************************
    // receive side
    // ****************************************
    typedef enum logic [1:0] {RX_COLLECT, RX_FETCH, RX_COMMIT} rx_state_t;
    rx_state_t     rx_state_ff;
    logic [3:0]    rx_cnt_ff;
    logic          rx_active_ff;
    logic [23:0]   rx_crc_ff;
    logic          rx_bad_ff;
    logic          rx_ready_ff;
    logic [2:0]    fetch_ff;
    logic [7:0]    b0_ff;
    logic [7:0]    b2_ff;
    logic [7:0]    b4_ff;
    logic [7:0]    bst_ff;
    logic [3:0]    rx_pos;
    logic [23:0]   rx_crc_in;
    logic          rx_take;
    logic          rx_miss;
    logic [3:0]    rd_addr;
    logic [7:0]    rd_data;
    ssm_pkg::cmd_t nxt_cmd;

    assign rx_pos    = rx_first ? 4'h0 : rx_cnt_ff;
    assign rx_crc_in = rx_first ? CRC_SEED : rx_crc_ff;
    // bytes past the crc or without a first byte are dropped
    assign rx_take   = rx_valid & rx_ready_ff
                     & (rx_first | (rx_active_ff & rx_cnt_ff <= ssm_pkg::OUT_B_CRC_LL));

    // compare received crc bytes, high first
    always_comb begin
        case (rx_pos)
            ssm_pkg::OUT_B_CRC_HH: rx_miss = rx_data != rx_crc_ff[23:16];
            ssm_pkg::OUT_B_CRC_LH: rx_miss = rx_data != rx_crc_ff[15:8];
            ssm_pkg::OUT_B_CRC_LL: rx_miss = rx_data != rx_crc_ff[7:0];
            default:               rx_miss = 1'b0;
        endcase
    end

    // fetch order: select 1, select 2, start, status
    always_comb begin
        case (fetch_ff)
            3'h0:    rd_addr = ssm_pkg::OUT_B_SEL1;
            3'h1:    rd_addr = ssm_pkg::OUT_B_SEL2;
            3'h2:    rd_addr = ssm_pkg::OUT_B_START;
            default: rd_addr = ssm_pkg::OUT_B_STATUS;
        endcase
    end

    // command bytes 0..5 kept, reserved byte 6 never read
    // bytes 0..7 kept; crc bytes are only compared
    tel_buf #(.WIDTH(8), .DEPTH(ssm_pkg::OUT_LEN)) u_buf (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .wr_en   (rx_take && rx_pos <= ssm_pkg::OUT_B_STATUS),
        .wr_addr (rx_pos),
        .wr_data (rx_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // collect, check, then read back the bytes that matter
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_state_ff  <= RX_COLLECT;
            rx_cnt_ff    <= 4'h0;
            rx_active_ff <= 1'b0;
            rx_crc_ff    <= CRC_SEED;
            rx_bad_ff    <= 1'b0;
            rx_ready_ff  <= 1'b1;
            fetch_ff     <= 3'h0;
            b0_ff        <= 8'h00;
            b2_ff        <= 8'h00;
            b4_ff        <= 8'h00;
            bst_ff       <= 8'h00;
        end else begin
            case (rx_state_ff)
                RX_COLLECT: begin
                    if (rx_take) begin
                        rx_cnt_ff    <= 4'(rx_pos + 4'h1);
                        rx_active_ff <= rx_pos != ssm_pkg::OUT_B_CRC_LL;
                        rx_bad_ff    <= (rx_first ? 1'b0 : rx_bad_ff) | rx_miss;
                        if (rx_pos < ssm_pkg::OUT_B_CRC_HH) begin
                            rx_crc_ff <= ssm_pkg::crc_byte(rx_crc_in, rx_data, CRC_POLY);
                        end
                        if (rx_pos == ssm_pkg::OUT_B_CRC_LL && !rx_bad_ff && !rx_miss) begin
                            rx_state_ff <= RX_FETCH;
                            rx_ready_ff <= 1'b0;
                            fetch_ff    <= 3'h0;
                        end
                    end
                end
                RX_FETCH: begin
                    fetch_ff <= 3'(fetch_ff + 3'h1);
                    case (fetch_ff)
                        3'h1:    b0_ff  <= rd_data;
                        3'h2:    b2_ff  <= rd_data;
                        3'h3:    b4_ff  <= rd_data;
                        3'h4:    bst_ff <= rd_data;
                        default: ;
                    endcase
                    if (fetch_ff == 3'h4) begin
                        rx_state_ff <= RX_COMMIT;
                    end
                end
                RX_COMMIT: begin
                    rx_state_ff <= RX_COLLECT;
                    rx_ready_ff <= 1'b1;
                end
                default: rx_state_ff <= RX_COLLECT;
            endcase
        end
    end

    // ****************************************
    // decode by function mode
    // ****************************************
    // layout follows the configured mode
    always_comb begin
        nxt_cmd = '0;
        case (ssm_pkg::mode_t'(func_mode))
            ssm_pkg::MODE_ONE_5_10: begin
                nxt_cmd.sel_grp1 = b0_ff[ssm_pkg::SEL_W-1:0];
                nxt_cmd.start_warn = b4_ff[ssm_pkg::BIT_WARN];
                nxt_cmd.start_prot = b4_ff[ssm_pkg::BIT_PROT];
            end
            ssm_pkg::MODE_ONE_100: begin
                nxt_cmd.sel_grp1 = b0_ff[ssm_pkg::SEL_W-1:0];
                nxt_cmd.sel_grp2 = b2_ff[ssm_pkg::SEL_W-1:0];
                nxt_cmd.start_warn = b4_ff[ssm_pkg::BIT_WARN];
                nxt_cmd.start_prot = b4_ff[ssm_pkg::BIT_PROT];
            end
            // other layouts not served here: safe all-off
            default: nxt_cmd = '0;
        endcase
    end

    ssm_pkg::cmd_t        cmd_ff;
    ssm_pkg::field_pair_t release_ff;
    logic [7:0]           rx_status_ff;
    logic                 telegram_ok_ff;
    logic                 crc_err_ff;

    // cmd and rx_status only change on a good telegram; crc_err flags a bad one
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cmd_ff         <= '0;
            release_ff     <= '0;
            rx_status_ff   <= 8'h00;
            telegram_ok_ff <= 1'b0;
            crc_err_ff     <= 1'b0;
        end else begin
            telegram_ok_ff <= rx_state_ff == RX_COMMIT;
            // a failed crc leaves commands untouched
            crc_err_ff     <= rx_take && rx_pos == ssm_pkg::OUT_B_CRC_LL
                              && (rx_bad_ff || rx_miss);
            release_ff     <= '0;
            if (rx_state_ff == RX_COMMIT) begin
                cmd_ff       <= nxt_cmd;
                rx_status_ff <= bst_ff;
                // release on a fresh start edge only
                release_ff.warn <= nxt_cmd.start_warn & ~cmd_ff.start_warn;
                release_ff.prot <= nxt_cmd.start_prot & ~cmd_ff.start_prot;
            end
        end
    end

    assign rx_ready    = rx_ready_ff;
    assign cmd         = cmd_ff;
    assign release_a   = release_ff;
    assign rx_status   = rx_status_ff;
    assign telegram_ok = telegram_ok_ff;
    assign crc_err     = crc_err_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    tx_func_a_a: assert property (tx_state_ff == TX_IDLE && tx_start |=>
        tx_data_ff == {6'h00, $past(func_a_prot_field_free), $past(func_a_warn_field_free)})
        else $error("byte 0 does not carry function A field state");
    tx_func_b_a: assert property (tx_take && tx_idx_ff == ssm_pkg::IN_B_FUNC_A |=>
        tx_data_ff == {6'h00, fb_ff})
        else $error("byte 1 does not carry function B field state");
    tx_status_a: assert property (tx_take
        && (tx_idx_ff == ssm_pkg::IN_B_FUNC_B || tx_idx_ff == ssm_pkg::IN_B_RSV)
        |=> tx_data_ff == ((tx_idx_ff == ssm_pkg::IN_B_STATUS) ? st_ff : 8'h00))
        else $error("reserved byte or status byte wrong");
    tx_crc_tail_a: assert property (tx_take && tx_idx_ff == ssm_pkg::IN_B_CRC_HH |=>
        tx_data_ff == tx_crc_ff[15:8] && tx_last_ff == 1'b0)
        else $error("crc middle byte wrong");
    rx_sel_a: assert property (rx_state_ff == RX_COMMIT
        && func_mode == ssm_pkg::MODE_ONE_5_10 |=> cmd_ff.sel_grp2 == '0
        && cmd_ff.sel_grp1 == $past(b0_ff[ssm_pkg::SEL_W-1:0]))
        else $error("5/10 pair select decode wrong");
    rx_grp2_a: assert property (rx_state_ff == RX_COMMIT
        && func_mode == ssm_pkg::MODE_ONE_100
        |=> cmd_ff.sel_grp2 == $past(b2_ff[ssm_pkg::SEL_W-1:0]))
        else $error("group 2 select decode wrong");
    rx_start_a: assert property (rx_state_ff == RX_COMMIT && !func_mode[1]
        |=> cmd_ff.start_warn == $past(b4_ff[ssm_pkg::BIT_WARN]) && telegram_ok_ff)
        else $error("start bit decode wrong");
    rx_other_a: assert property (rx_state_ff == RX_COMMIT && func_mode[1]
        |=> cmd_ff == '0)
        else $error("unserved mode must give no commands");
    release_edge_a: assert property (release_ff.warn |->
        cmd_ff.start_warn && !$past(cmd_ff.start_warn))
        else $error("release without a start edge");
    crc_hold_a: assert property (crc_err_ff |-> $stable(cmd_ff)
        ##1 rx_state_ff == RX_COLLECT)
        else $error("bad telegram changed commands");

    tx_done_c: cover property (tx_take && tx_last_ff);
    rx_good_c: cover property (telegram_ok_ff && release_ff.prot);
    rx_bad_c:  cover property (crc_err_ff);

endmodule : safe_signal_telegram_mapper

// ---- rtl/ssm_pkg.sv ----
// constants, types and the crc step for the safe telegram mapper
// assumes byte-wide telegram links and a single 10 MHz clock domain
package ssm_pkg;

    // ****************************************
    // telegram lengths and byte positions
    // ****************************************
    localparam int unsigned IN_LEN       = 7;
    localparam int unsigned OUT_LEN      = 11;
    localparam logic [3:0]  IN_B_FUNC_A  = 4'h0;
    localparam logic [3:0]  IN_B_FUNC_B  = 4'h1;
    localparam logic [3:0]  IN_B_RSV     = 4'h2;
    localparam logic [3:0]  IN_B_STATUS  = 4'h3;
    localparam logic [3:0]  IN_B_CRC_HH  = 4'h4;
    localparam logic [3:0]  IN_B_CRC_LH  = 4'h5;
    localparam logic [3:0]  IN_B_CRC_LL  = 4'h6;
    localparam logic [3:0]  OUT_B_SEL1   = 4'h0;
    localparam logic [3:0]  OUT_B_SEL2   = 4'h2;
    localparam logic [3:0]  OUT_B_START  = 4'h4;
    localparam logic [3:0]  OUT_B_RSV    = 4'h6;
    localparam logic [3:0]  OUT_B_STATUS = 4'h7;
    localparam logic [3:0]  OUT_B_CRC_HH = 4'h8;
    localparam logic [3:0]  OUT_B_CRC_LH = 4'h9;
    localparam logic [3:0]  OUT_B_CRC_LL = 4'hA;

    // ****************************************
    // bit positions and field widths
    // ****************************************
    localparam int unsigned BIT_WARN = 0;
    localparam int unsigned BIT_PROT = 1;
    localparam int unsigned SEL_W    = 5;
    localparam int unsigned CRC_W    = 24;

    // crc defaults, overridable at the top
    localparam logic [23:0] CRC_POLY_DEF = 24'h800063;
    localparam logic [23:0] CRC_SEED_DEF = 24'h000000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_ONE_5_10,
        MODE_ONE_100,
        MODE_MULTI_CFG,
        MODE_TWO_FUNC
    } mode_t;

    typedef struct packed {
        logic prot;
        logic warn;
    } field_pair_t;

    typedef struct packed {
        logic [SEL_W-1:0] sel_grp1;
        logic [SEL_W-1:0] sel_grp2;
        logic             start_prot;
        logic             start_warn;
    } cmd_t;

    // one byte of msb-first crc, shared by send and receive paths
    function automatic logic [23:0] crc_byte(input logic [23:0] crc,
                                             input logic [7:0]  data,
                                             input logic [23:0] poly);
        logic [23:0] c;
        c = crc ^ {data, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            c = c[23] ? ((c << 1) ^ poly) : (c << 1);
        end
        return c;
    endfunction : crc_byte

endpackage : ssm_pkg

// ---- rtl/tel_buf.sv ----
// small receive buffer for one controller telegram
// assumes one writer and one reader in the mclk domain
`timescale 1ns/10ps
module tel_buf #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 11
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);

    // ****************************************
    // storage
    // ****************************************
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] rd_data_ff;

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("tel_buf needs DEPTH >= 2 and WIDTH >= 1");
    end

    // write port; no reset, contents are always written before read
    always_ff @(posedge mclk) begin
        if (wr_en && wr_addr < DEPTH) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    // registered read, one cycle latency
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rd_data_ff <= '0;
        end else begin
            rd_data_ff <= (rd_addr < DEPTH) ? mem_ff[rd_addr] : '0;
        end
    end

    assign rd_data = rd_data_ff;

endmodule : tel_buf

// ---- test/ctl_model.sv ----
// controller model: reads device telegrams, sends command telegrams
// assumes the mapper byte handshakes on mclk and the default crc
`timescale 1ns/10ps
module ctl_model (
    input  wire logic       mclk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic            rx_first,
    output logic [7:0]      rx_data,
    input  wire logic       rx_ready,
    output logic            got,
    output logic [55:0]     got_tel,
    output logic            hung
);
    // ****************
    // controller side
    // ****************
    logic [55:0] acc;
    initial begin
        {tx_ready, rx_valid, rx_first, got, hung, rx_data} = '0;
    end
    // msb-first crc over the top n bytes of d
    function automatic logic [23:0] crc24(input logic [63:0] d, input int n);
        logic [23:0] c;
        c = 24'h000000;
        for (int i = 0; i < n; i++) begin
            c ^= {d[63-8*i-:8], 16'h0000};
            for (int j = 0; j < 8; j++) c = c[23] ? (c << 1) ^ 24'h800063 : c << 1;
        end
        return c;
    endfunction : crc24
    // random stalls, so the device must hold each byte
    always @(posedge mclk) tx_ready <= #1 ($urandom_range(3) != 0);
    // gather device bytes, pulse got at the last one
    always @(posedge mclk) begin
        got <= 1'h0;
        if (tx_valid && tx_ready) begin
            acc = {acc[47:0], tx_data};
            if (tx_last) {got, got_tel} <= {1'h1, acc};
        end
    end
    // status, then crc high first; bad spoils the crc on purpose
    task automatic send(input logic [63:0] p, input logic bad, input int n);
        logic [87:0] t;
        int          w;
        t = {p, crc24(p, 8) ^ {23'h0, bad}};
        for (int i = 0; i < n; i++) begin
            {rx_valid, rx_first, rx_data} = {1'h1, i == 0, t[87-8*i-:8]};
            for (w = 0; rx_ready !== 1'h1 && w < 50; w++) begin
                @(posedge mclk);
                #1;
            end
            hung |= (w == 50);
            @(posedge mclk);
            #1;
        end
        // released data shows the inverse, never the last byte
        {rx_valid, rx_first, rx_data} = {2'h0, ~rx_data};
    endtask : send
endmodule : ctl_model

// ---- test/safe_signal_telegram_mapper_tb_top.sv ----
// bench for the safe telegram mapper against the controller model
// assumes default crc parameters and ctl_model on the far side
`timescale 1ns/10ps
module safe_signal_telegram_mapper_tb_top;
    // ****************
    // signals and notes
    // ****************
    logic                 mclk = 1'h0;
    logic                 rst_b, tx_start, tx_ready, tx_valid, tx_last, tx_busy, got;
    logic                 rx_valid, rx_first, rx_ready, telegram_ok, crc_err, hung;
    logic [1:0]           func_mode;
    logic [3:0]           ff;
    logic [7:0]           tx_status, tx_data, rx_data, rx_status, est;
    logic [55:0]          got_tel;
    ssm_pkg::cmd_t        cmd, ecmd;
    ssm_pkg::field_pair_t release_a;
    logic [55:0]          tq[$];
    logic [22:0]          rq[$];
    int                   err_total, n_checks;

    safe_signal_telegram_mapper dut (.mclk(mclk), .rst_b(rst_b), .func_mode(func_mode),
        .func_a_warn_field_free(ff[0]), .func_a_prot_field_free(ff[1]),
        .func_b_warn_field_free(ff[2]), .func_b_prot_field_free(ff[3]),
        .tx_status(tx_status), .tx_start(tx_start), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_busy(tx_busy), .rx_valid(rx_valid),
        .rx_first(rx_first), .rx_data(rx_data), .rx_ready(rx_ready), .cmd(cmd),
        .release_a(release_a), .rx_status(rx_status), .telegram_ok(telegram_ok),
        .crc_err(crc_err));
    ctl_model m (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
        .rx_ready(rx_ready), .got(got), .got_tel(got_tel), .hung(hung));

    // 10 MHz
    always #50 mclk = ~mclk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    task automatic time_out(input string s);
        err_total++;
        $display("ERROR %0t %s wait ran out", $time, s);
        give_verdict();
    endtask : time_out
    task automatic chk_tel(input logic [55:0] g, input logic [55:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t telegram %h expected %h", $time, g, e);
        end
    endtask : chk_tel
    task automatic chk_rx(input logic [22:0] g, input logic [22:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t command result %h expected %h", $time, g, e);
        end
    endtask : chk_rx
    // wait for every noted result, bounded
    task automatic drain();
        int w;
        w = 0;
        do begin
            @(posedge mclk);
            #1;
            w++;
        end while ((tq.size() != 0 || rq.size() != 0 || tx_busy !== 1'h0) && w < 400);
        if (w == 400) time_out("result");
    endtask : drain
    // field bits in bits 0 and 1, rest zero, crc over bytes 0..3
    task automatic send_dev(input logic [3:0] f, input logic [7:0] st);
        logic [31:0] h;
        h = {6'h00, f[1:0], 6'h00, f[3:2], 8'h00, st};
        tq.push_back({h, m.crc24({h, 32'h0}, 4)});
        {ff, tx_status, tx_start} = {f, st, 1'h1};
        @(posedge mclk);
        #1;
        // start held while busy is ignored; later field changes must not leak
        ff = ~f;
        repeat (2) @(posedge mclk);
        #1;
        tx_start = 1'h0;
        drain();
    endtask : send_dev
    // decode by mode, release on a rising start bit
    task automatic send_cmd(input logic [1:0] md, input logic [63:0] p, input logic bad);
        ssm_pkg::cmd_t c;
        c = '0;
        if (md < 2'h2) c = {p[60:56], md == 2'h1 ? p[44:40] : 5'h00, p[25:24]};
        if (bad) rq.push_back({1'h1, ecmd, 2'h0, est});
        else rq.push_back({1'h0, c, c[1:0] & ~ecmd[1:0], p[7:0]});
        if (!bad) {ecmd, est} = {c, p[7:0]};
        func_mode = md;
        m.send(p, bad, 11);
        drain();
    endtask : send_cmd
    // oldest note against each result as it appears
    always @(posedge mclk) begin
        if (hung === 1'h1) time_out("handshake");
        if (got === 1'h1) chk_tel(got_tel, tq.size() ? tq.pop_front() : 'x);
        if (telegram_ok === 1'h1 || crc_err === 1'h1)
            chk_rx({crc_err, cmd, release_a, rx_status}, rq.size() ? rq.pop_front() : 'x);
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(18));
        {rst_b, tx_start, func_mode, ff, tx_status, ecmd, est} = '0;
        {err_total, n_checks} = '0;
        repeat (16) @(posedge mclk);
        #1;
        rst_b = 1'h1;
        chk_rx({crc_err, cmd, release_a, rx_status}, 23'h0);
        $display("test reset done");
        for (int k = 0; k < 16; k++) send_dev(k[3:0], 8'($urandom));
        $display("test device telegram done");
        // reserved places carry random junk throughout
        for (int k = 0; k < 12; k++) send_cmd(k[1:0], {$urandom, $urandom}, k == 9);
        $display("test command modes done");
        send_cmd(2'h3, {$urandom, $urandom}, 1'h0);
        m.send(64'hFFFF_FFFF_FFFF_FFFF, 1'h0, 4);
        drain();
        send_cmd(2'h0, 64'h1FFF_FFFF_03FF_FFA5, 1'h0);
        send_cmd(2'h1, 64'h1F00_1F00_0300_0000, 1'h1);
        $display("test abort and release done");
        give_verdict();
    end
endmodule : safe_signal_telegram_mapper_tb_top
